/* irq_vector_pkg.sv */
// Purpose : shared constants for the vectored interrupt block, plus the pin synchroniser
// Assumes : one clock, synchronous active-low reset
// Notes   : vector table indexed by source, index 0 is the highest priority
`default_nettype none

// ==========================================================================
// constants
// ==========================================================================
package irq_vector_pkg;
  localparam int NUM_SRC  = 8;
  localparam int IDX_W    = 3;
  localparam int VEC_W    = 16;
  localparam int WAKE_W   = 8;
  localparam int DATA_W   = 4;
  localparam int PIN_W    = DATA_W + WAKE_W;
  localparam int PRIME_W  = 3;

  // source index, also the priority rank
  localparam int IDX_DAC   = 0;
  localparam int IDX_TMR1  = 1;
  localparam int IDX_TMR2  = 2;
  localparam int IDX_PIN2  = 3;
  localparam int IDX_PIN3  = 4;
  localparam int IDX_WAKE  = 5;
  localparam int IDX_PIN4  = 6;
  localparam int IDX_PIN5  = 7;

  // position of each pin in the synchronised pin vector
  localparam int PIN_TWO   = 0;
  localparam int PIN_THREE = 1;
  localparam int PIN_FOUR  = 2;
  localparam int PIN_FIVE  = 3;
  localparam int PIN_WAKE  = 4;

  localparam logic [NUM_SRC-1:0][VEC_W-1:0] SRC_VECTOR = {
    16'h7ff7, 16'h7ff6, 16'h7ff5, 16'h7ff4,
    16'h7ff3, 16'h7ff2, 16'h7ff1, 16'h7ff0
  };
  localparam logic [VEC_W-1:0]   VEC_RESET   = 16'h7fff;
  localparam logic [NUM_SRC-1:0] FLAGS_RESET = 8'h00;
  localparam logic [NUM_SRC-1:0] ONE_SRC     = 8'h01;
  localparam logic [IDX_W-1:0]   IDX_RESET   = 3'h0;
  localparam logic [PRIME_W-1:0] PRIME_RESET = 3'h0;
endpackage

// ==========================================================================
// two-flop synchroniser with history and a primed flag
// ==========================================================================
module pin_sync (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic pin,
  output logic      level,
  output logic      prev,
  output logic      primed
);
  logic                                meta;
  logic [irq_vector_pkg::PRIME_W-1:0] prime_sr;

  // primed blocks a false edge from the reset value of the history flops
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta     <= 1'b0;
      level    <= 1'b0;
      prev     <= 1'b0;
      prime_sr <= irq_vector_pkg::PRIME_RESET;
    end else begin
      meta     <= pin;
      level    <= meta;
      prev     <= level;
      prime_sr <= {prime_sr[irq_vector_pkg::PRIME_W-2:0], 1'b1};
    end
  end

  assign primed = prime_sr[irq_vector_pkg::PRIME_W-1];
endmodule

`default_nettype wire

/* vectored_interrupt_priority.sv */
// Purpose : prioritised vectored interrupt logic for the core's sequencer
// Assumes : timer underflows and comparator level are synchronous to clk
// Notes   : vector and request stay frozen from request to acknowledge
//
// How it works
// - dac timer underflow, top priority, 7ff0
// - timer one underflow, second, 7ff1
// - timer two underflow, third, 7ff2
// - data pin two rising, fourth, 7ff3
// - data pin three falling, fifth, 7ff4
// - wake port all-high to any low, 7ff5
// - data pin four rising, seventh, 7ff6
// - data pin five falling, lowest, 7ff7
// - comparator enable drives the two lowest sources from comparator rise and fall
// - reset gives unmaskable dispatch to 7fff
`default_nettype none

module vectored_interrupt_priority (
  input  wire logic                                 clk,
  input  wire logic                                 rstn,
  input  wire logic                                 dac_timer_underflow,
  input  wire logic                                 timer_one_underflow,
  input  wire logic                                 timer_two_underflow,
  input  wire logic                                 data_pin_two,
  input  wire logic                                 data_pin_three,
  input  wire logic                                 data_pin_four,
  input  wire logic                                 data_pin_five,
  input  wire logic [irq_vector_pkg::WAKE_W-1:0]   wake_port,
  input  wire logic                                 comparator_enable,
  input  wire logic                                 comparator_out,
  input  wire logic                                 master_enable,
  input  wire logic [irq_vector_pkg::NUM_SRC-1:0]  irq_enable,
  input  wire logic [irq_vector_pkg::NUM_SRC-1:0]  flag_clear,
  input  wire logic                                 irq_ack,
  output logic                                      irq_request,
  output logic      [irq_vector_pkg::VEC_W-1:0]    vector_addr,
  output logic                                      reset_dispatch,
  output logic      [irq_vector_pkg::NUM_SRC-1:0]  pending,
  output logic      [irq_vector_pkg::NUM_SRC-1:0]  service_done
);

  // ========================================================================
  // declarations
  // ========================================================================
  typedef enum logic [1:0] {st_reset, st_idle, st_request} state_type;

  state_type                               state;
  state_type                               next_state;
  logic [irq_vector_pkg::IDX_W-1:0]       served_index;
  logic [irq_vector_pkg::IDX_W-1:0]       next_index;
  logic [irq_vector_pkg::IDX_W-1:0]       pick;
  logic [irq_vector_pkg::VEC_W-1:0]       next_vector;
  logic                                    next_request;
  logic                                    next_reset_dispatch;
  logic                                    clear_served;
  logic [irq_vector_pkg::NUM_SRC-1:0]     next_pending;
  logic [irq_vector_pkg::NUM_SRC-1:0]     next_service_done;
  logic [irq_vector_pkg::NUM_SRC-1:0]     set_event;
  logic [irq_vector_pkg::NUM_SRC-1:0]     clr_event;
  logic [irq_vector_pkg::NUM_SRC-1:0]     served_onehot;
  logic [irq_vector_pkg::NUM_SRC-1:0]     ready;
  logic                                    any_ready;

  logic [irq_vector_pkg::PIN_W-1:0]       raw_pins;
  logic [irq_vector_pkg::PIN_W-1:0]       pin_level;
  logic [irq_vector_pkg::PIN_W-1:0]       pin_prev;
  logic [irq_vector_pkg::PIN_W-1:0]       pin_primed;

  logic                                    pin2_rise_irq;
  logic                                    pin3_fall_irq;
  logic                                    wake_port_fall_irq;
  logic                                    pin4_rise_irq;
  logic                                    pin5_fall_irq;
  logic                                    data4_rise;
  logic                                    data5_fall;
  logic                                    cmp_rise;
  logic                                    cmp_fall;
  logic                                    cmp_last;
  logic                                    cmp_primed;
  logic                                    wake_now_high;
  logic                                    wake_prev_high;

  // ========================================================================
  // pin synchronisers
  // ========================================================================
  assign raw_pins = {wake_port, data_pin_five, data_pin_four, data_pin_three, data_pin_two};

  genvar g;
  generate
    for (g = 0; g < irq_vector_pkg::PIN_W; g++) begin : g_sync
      pin_sync u_sync (
        .clk    (clk),
        .rstn   (rstn),
        .pin    (raw_pins[g]),
        .level  (pin_level[g]),
        .prev   (pin_prev[g]),
        .primed (pin_primed[g])
      );
    end
  endgenerate

  // ========================================================================
  // edge detection
  // ========================================================================
  assign pin2_rise_irq = pin_primed[irq_vector_pkg::PIN_TWO] &
                         pin_level[irq_vector_pkg::PIN_TWO] &
                         ~pin_prev[irq_vector_pkg::PIN_TWO];
  assign pin3_fall_irq = pin_primed[irq_vector_pkg::PIN_THREE] &
                         ~pin_level[irq_vector_pkg::PIN_THREE] &
                         pin_prev[irq_vector_pkg::PIN_THREE];
  assign data4_rise    = pin_primed[irq_vector_pkg::PIN_FOUR] &
                         pin_level[irq_vector_pkg::PIN_FOUR] &
                         ~pin_prev[irq_vector_pkg::PIN_FOUR];
  assign data5_fall    = pin_primed[irq_vector_pkg::PIN_FIVE] &
                         ~pin_level[irq_vector_pkg::PIN_FIVE] &
                         pin_prev[irq_vector_pkg::PIN_FIVE];

  // one event per all-high episode, further falls while low are ignored
  assign wake_now_high  = &pin_level[irq_vector_pkg::PIN_W-1:irq_vector_pkg::PIN_WAKE];
  assign wake_prev_high = &pin_prev[irq_vector_pkg::PIN_W-1:irq_vector_pkg::PIN_WAKE];
  assign wake_port_fall_irq = pin_primed[irq_vector_pkg::PIN_WAKE] &
                              wake_prev_high & ~wake_now_high;

  // comparator is on-chip and already synchronous, so no synchroniser here
  assign cmp_rise = cmp_primed & comparator_out & ~cmp_last;
  assign cmp_fall = cmp_primed & ~comparator_out & cmp_last;

  assign pin4_rise_irq = comparator_enable ? cmp_rise : data4_rise;
  assign pin5_fall_irq = comparator_enable ? cmp_fall : data5_fall;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmp_last   <= 1'b0;
      cmp_primed <= 1'b0;
    end else begin
      cmp_last   <= comparator_out;
      cmp_primed <= 1'b1;
    end
  end

  // ========================================================================
  // pending flags
  // ========================================================================
  always_comb begin
    set_event                           = irq_vector_pkg::FLAGS_RESET;
    set_event[irq_vector_pkg::IDX_DAC]  = dac_timer_underflow;
    set_event[irq_vector_pkg::IDX_TMR1] = timer_one_underflow;
    set_event[irq_vector_pkg::IDX_TMR2] = timer_two_underflow;
    set_event[irq_vector_pkg::IDX_PIN2] = pin2_rise_irq;
    set_event[irq_vector_pkg::IDX_PIN3] = pin3_fall_irq;
    set_event[irq_vector_pkg::IDX_WAKE] = wake_port_fall_irq;
    set_event[irq_vector_pkg::IDX_PIN4] = pin4_rise_irq;
    set_event[irq_vector_pkg::IDX_PIN5] = pin5_fall_irq;
  end

  assign served_onehot = irq_vector_pkg::ONE_SRC << served_index;
  assign clr_event     = (clear_served ? served_onehot : irq_vector_pkg::FLAGS_RESET) |
                         flag_clear;
  // a new event wins over a clear in the same cycle
  assign next_pending  = set_event | (pending & ~clr_event);
  assign next_service_done = clear_served ? served_onehot : irq_vector_pkg::FLAGS_RESET;

  // ========================================================================
  // priority selection
  // ========================================================================
  assign ready     = pending & irq_enable;
  assign any_ready = master_enable & (|ready);

  always_comb begin
    pick = irq_vector_pkg::IDX_RESET;
    // walk from lowest priority upward so the highest ready one wins
    for (int i = irq_vector_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (ready[i]) begin
        pick = irq_vector_pkg::IDX_W'(i);
      end
    end
  end

  // ========================================================================
  // dispatch sequencer
  // ========================================================================
  always_comb begin
    next_state          = state;
    next_index          = served_index;
    next_vector         = vector_addr;
    next_request        = irq_request;
    next_reset_dispatch = reset_dispatch;
    clear_served        = 1'b0;
    case (state)
      st_reset: begin
        // unmaskable: neither master_enable nor irq_enable gates it
        if (irq_ack) begin
          next_state          = st_idle;
          next_request        = 1'b0;
          next_reset_dispatch = 1'b0;
        end
      end
      st_idle: begin
        if (any_ready) begin
          next_state   = st_request;
          next_request = 1'b1;
          next_index   = pick;
          next_vector  = irq_vector_pkg::SRC_VECTOR[pick];
        end
      end
      st_request: begin
        // vector held steady; a higher source arriving now waits its turn
        if (irq_ack) begin
          next_state   = st_idle;
          next_request = 1'b0;
          clear_served = 1'b1;
        end
      end
      default: begin
        next_state          = st_reset;
        next_request        = 1'b1;
        next_reset_dispatch = 1'b1;
        next_vector         = irq_vector_pkg::VEC_RESET;
      end
    endcase
  end

  // ========================================================================
  // registers
  // ========================================================================
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state          <= st_reset;
      irq_request    <= 1'b1;
      reset_dispatch <= 1'b1;
      vector_addr    <= irq_vector_pkg::VEC_RESET;
      served_index   <= irq_vector_pkg::IDX_RESET;
      pending        <= irq_vector_pkg::FLAGS_RESET;
      service_done   <= irq_vector_pkg::FLAGS_RESET;
    end else begin
      state          <= next_state;
      irq_request    <= next_request;
      reset_dispatch <= next_reset_dispatch;
      vector_addr    <= next_vector;
      served_index   <= next_index;
      pending        <= next_pending;
      service_done   <= next_service_done;
    end
  end

endmodule

`default_nettype wire

/* vectored_interrupt_priority_checker.sv */
// Purpose : port-level checks on vector dispatch and acknowledge
// Assumes : one clock, synchronous active-low reset
// Notes   : pin edge sources are checked by the bench through the vector taken
`default_nettype none

// ======================================================================
// checker
// ======================================================================
module vectored_interrupt_priority_checker (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        dac_timer_underflow,
  input wire logic        timer_one_underflow,
  input wire logic        timer_two_underflow,
  input wire logic        master_enable,
  input wire logic [7:0]  irq_enable,
  input wire logic        irq_ack,
  input wire logic        irq_request,
  input wire logic [15:0] vector_addr,
  input wire logic        reset_dispatch,
  input wire logic [7:0]  pending,
  input wire logic [7:0]  service_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire logic [2:0] tmr = {timer_two_underflow, timer_one_underflow, dac_timer_underflow};

  function automatic logic [2:0] low_idx(input logic [7:0] v);
    low_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) low_idx = i[2:0];
    end
  endfunction

  a_reset_vector: assert property ($rose(rstn) |->
    irq_request && reset_dispatch && vector_addr == 16'h7fff)
    else $error("reset dispatch missing");
  a_reset_held: assert property (reset_dispatch |->
    irq_request && vector_addr == 16'h7fff)
    else $error("reset vector not held");
  a_reset_no_done: assert property (reset_dispatch && irq_ack |=>
    !reset_dispatch && !irq_request && service_done == 8'h00)
    else $error("reset ack wrong");
  a_vector_frozen: assert property (irq_request && !irq_ack |=>
    irq_request && $stable(vector_addr))
    else $error("request not held");
  a_ack_done: assert property (irq_request && irq_ack && !reset_dispatch |=>
    !irq_request && service_done == (8'h01 << $past(vector_addr[2:0])))
    else $error("service pulse wrong");
  a_vector_table: assert property (irq_request && !reset_dispatch |->
    vector_addr[15:3] == 13'h0ffe)
    else $error("vector outside table");
  a_highest_first: assert property ($rose(irq_request) && !reset_dispatch |->
    vector_addr[2:0] == low_idx($past(pending & irq_enable)))
    else $error("priority wrong");
  a_master_gate: assert property (!irq_request && !master_enable |=> !irq_request)
    else $error("dispatch while disabled");
  a_timer_pending: assert property (|tmr |=>
    (pending[2:0] & $past(tmr)) == $past(tmr))
    else $error("timer flag lost");

  c_reset_ack: cover property (reset_dispatch && irq_ack);
  c_lowest: cover property (service_done[7]);
  c_wake: cover property (service_done[5]);
endmodule

bind vectored_interrupt_priority vectored_interrupt_priority_checker chk (
  .clk(clk), .rstn(rstn), .dac_timer_underflow(dac_timer_underflow),
  .timer_one_underflow(timer_one_underflow), .timer_two_underflow(timer_two_underflow),
  .master_enable(master_enable), .irq_enable(irq_enable), .irq_ack(irq_ack),
  .irq_request(irq_request), .vector_addr(vector_addr), .reset_dispatch(reset_dispatch),
  .pending(pending), .service_done(service_done));
`default_nettype wire

/* core_sequencer_model.sv */
// Purpose : behavioural instruction sequencer taking vectors
// Assumes : ack after a programmable number of cycles
// Notes   : records the last vector taken and a running count
`default_nettype none

// ======================================================================
// model
// ======================================================================
module core_sequencer_model (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            irq_request,
  input  wire logic [irq_vector_pkg::VEC_W-1:0] vector_addr,
  input  wire logic [3:0]                      ack_delay,
  output logic                                 irq_ack,
  output logic      [irq_vector_pkg::VEC_W-1:0] last_vector,
  output int                                   taken_cnt
);
  logic [3:0] wait_cnt;
  initial begin
    irq_ack = 1'b0;
    last_vector = 16'h0000;
    taken_cnt = 0;
    wait_cnt = 4'h0;
  end
  // ack is one pulse only; a held ack would hide a request that never drops
  always @(posedge clk) begin
    #1;
    if (!rstn || !irq_request || irq_ack) begin
      irq_ack = 1'b0;
      wait_cnt = 4'h0;
    end else if (wait_cnt >= ack_delay) begin
      irq_ack = 1'b1;
      last_vector = vector_addr;
      taken_cnt = taken_cnt + 1;
    end else begin
      wait_cnt = wait_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* vectored_interrupt_priority_tb_top.sv */
// Purpose : self-checking bench for the vectored interrupt block
// Assumes : sequencer model acks every request
// Notes   : one row per source, awkward cases after the loop
`default_nettype none

// ======================================================================
// bench
// ======================================================================
module vectored_interrupt_priority_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int src; logic [15:0] vec; logic [3:0] dly;} row_type;
  row_type rows [8] = '{'{0, 16'h7ff0, 4'h0}, '{1, 16'h7ff1, 4'h3}, '{2, 16'h7ff2, 4'h1},
    '{3, 16'h7ff3, 4'h0}, '{4, 16'h7ff4, 4'h2}, '{5, 16'h7ff5, 4'h0}, '{6, 16'h7ff6, 4'h3},
    '{7, 16'h7ff7, 4'h1}};
  logic clk, rstn, dac, tm1, tm2, pin2, pin3, pin4, pin5, cmp_en, cmp_out, master, irq_ack;
  logic irq_request, reset_dispatch;
  logic [7:0] wake, irq_enable, flag_clear, pending, service_done;
  logic [15:0] vector_addr, last_vector;
  logic [3:0] ack_delay;
  int taken_cnt, error_cnt, samples_checked, n;

  vectored_interrupt_priority dut (.clk(clk), .rstn(rstn), .dac_timer_underflow(dac),
    .timer_one_underflow(tm1), .timer_two_underflow(tm2), .data_pin_two(pin2),
    .data_pin_three(pin3), .data_pin_four(pin4), .data_pin_five(pin5), .wake_port(wake),
    .comparator_enable(cmp_en), .comparator_out(cmp_out), .master_enable(master),
    .irq_enable(irq_enable), .flag_clear(flag_clear), .irq_ack(irq_ack),
    .irq_request(irq_request), .vector_addr(vector_addr), .reset_dispatch(reset_dispatch),
    .pending(pending), .service_done(service_done));
  core_sequencer_model core (.clk(clk), .rstn(rstn), .irq_request(irq_request),
    .vector_addr(vector_addr), .ack_delay(ack_delay), .irq_ack(irq_ack),
    .last_vector(last_vector), .taken_cnt(taken_cnt));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic tick(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic check_vec(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic check_flags(string name, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic wait_take(int prev);
    for (int i = 0; i < 40 && taken_cnt == prev; i++) tick(1);
  endtask
  task automatic fire(int src);
    case (src)
      0: begin dac = 1'b1; tick(1); dac = 1'b0; end
      1: begin tm1 = 1'b1; tick(1); tm1 = 1'b0; end
      2: begin tm2 = 1'b1; tick(1); tm2 = 1'b0; end
      3: pin2 = 1'b1;
      4: pin3 = 1'b0;
      5: begin wake[0] = 1'b0; tick(1); wake[3] = 1'b0; end
      6: pin4 = 1'b1;
      default: pin5 = 1'b0;
    endcase
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    #(40 * 4000);
    error_cnt++;
    results();
  end

  initial begin
    {dac, tm1, tm2, pin2, pin4, cmp_en, cmp_out, master, rstn} = '0;
    {pin3, pin5} = 2'b11;
    {wake, irq_enable, flag_clear, ack_delay} = {8'hff, 8'hff, 8'h00, 4'h2};
    error_cnt = 0;
    samples_checked = 0;
    tick(4);
    rstn = 1'b1;
    wait_take(0);
    check_vec("reset vector", 16'h7fff, last_vector);
    master = 1'b1;
    tick(4);
    foreach (rows[r]) begin
      ack_delay = rows[r].dly;
      n = taken_cnt;
      fire(rows[r].src);
      wait_take(n);
      check_vec("vector", rows[r].vec, last_vector);
      tick(3);
      {pin2, pin3, pin4, pin5, wake} = {4'b0101, 8'hff};
      tick(6);
      check_flags("pending after restore", 8'h00, pending);
    end
    cmp_en = 1'b1;
    pin4 = 1'b1;
    tick(8);
    check_flags("pin four in comparator mode", 8'h00, pending);
    n = taken_cnt;
    cmp_out = 1'b1;
    wait_take(n);
    check_vec("comparator rise", 16'h7ff6, last_vector);
    tick(3);
    n = taken_cnt;
    cmp_out = 1'b0;
    wait_take(n);
    check_vec("comparator fall", 16'h7ff7, last_vector);
    {cmp_en, pin4, master, irq_enable} = {3'b000, 8'h7f};
    tick(3);
    {dac, tm1, tm2, pin5} = 4'b1110;
    tick(1);
    {dac, tm1, tm2} = 3'b000;
    tick(6);
    check_flags("stacked pending", 8'h87, pending);
    master = 1'b1;
    for (int k = 0; k < 3; k++) begin
      n = taken_cnt;
      wait_take(n);
      check_vec("priority order", 16'h7ff0 + 16'(k), last_vector);
      tick(1);
    end
    tick(8);
    check_flags("masked stays", 8'h80, pending);
    flag_clear = 8'h80;
    tick(1);
    flag_clear = 8'h00;
    tick(1);
    check_flags("cleared", 8'h00, pending);
    {pin5, ack_delay, rstn} = {1'b1, 4'h8, 1'b0};
    tick(1);
    check_flags("reset dispatch", 8'h03, {6'h00, irq_request, reset_dispatch});
    check_vec("reset vector held", 16'h7fff, vector_addr);
    n = taken_cnt;
    rstn = 1'b1;
    wait_take(n);
    check_vec("second reset vector", 16'h7fff, last_vector);
    tick(12);
    check_flags("pending after second reset", 8'h00, pending);
    results();
  end
endmodule
`default_nettype wire
